// *** logic/nsrcfg_regs.sv ***
// Requantizer control and band tuning registers
`timescale 1ns/1ps
`default_nettype none
`include "nsrcfg_map.svh"
module nsrcfg_regs
	import nsrcfg_pkg::*;
(
	// Clock and reset
	input  wire logic                     CLK,
	input  wire logic                     RST_N,
	// Register port from serial control
	input  wire logic                     WR_EN,
	input  wire logic                     RD_EN,
	input  wire nsrcfg_pkg::nsrcfg_byte_t ADDR,
	input  wire nsrcfg_pkg::nsrcfg_byte_t WDATA,
	output nsrcfg_pkg::nsrcfg_byte_t      RDATA,
	output logic                          RVALID,
	// Requantizer settings
	output logic                          RQ_ENABLE,
	output nsrcfg_pkg::nsrcfg_bw_t        RQ_BW_MODE,
	output nsrcfg_pkg::nsrcfg_tune_t      RQ_TUNE,
	output logic                          RQ_TUNE_VALID,
	output logic [9:0]                    RQ_BAND_POS
);
	nsrcfg_byte_t ctrl_q;
	nsrcfg_byte_t tune_q;
	nsrcfg_byte_t rdata_q;
	logic         rvalid_q;
	logic         en_q;
	nsrcfg_bw_t   bw_q;
	logic         tok_q;
	logic [9:0]   pos_q;
	logic         tok_d;
	logic [9:0]   pos_d;
	logic [2:0]   mode_field;

	// ----------------------------------------
	// Register writes
	// ----------------------------------------
	always_ff @(posedge CLK)
	begin
		if (!RST_N)
		begin
			ctrl_q <= `NSRCFG_CTRL_RESET;
			tune_q <= `NSRCFG_TUNE_RESET;
		end
		else if (WR_EN)
		begin
			if (ADDR == `NSRCFG_CTRL_ADDR)
				ctrl_q <= WDATA & `NSRCFG_CTRL_MASK;
			else if (ADDR == `NSRCFG_TUNE_ADDR)
				tune_q <= WDATA & `NSRCFG_TUNE_MASK;
		end
	end

	// ----------------------------------------
	// Register reads, unmapped reads return zero
	// ----------------------------------------
	always_ff @(posedge CLK)
	begin
		if (!RST_N)
		begin
			rdata_q  <= 8'h00;
			rvalid_q <= 1'b0;
		end
		else
		begin
			rvalid_q <= RD_EN;
			if (!RD_EN)
				rdata_q <= 8'h00;
			else if (ADDR == `NSRCFG_CTRL_ADDR)
				rdata_q <= ctrl_q;
			else if (ADDR == `NSRCFG_TUNE_ADDR)
				rdata_q <= tune_q;
			else
				rdata_q <= 8'h00;
		end
	end

	// ----------------------------------------
	// Decoded settings
	// ----------------------------------------
	assign mode_field = ctrl_q[`NSRCFG_CTRL_MODE_MSB:`NSRCFG_CTRL_MODE_LSB];

	nsrcfg_tune_limit u_limit
	(
		.bw_33           (bw_q == NSRCFG_BW_33),
		.tune            (tune_q[5:0]),
		.tune_ok         (tok_d),
		.band_pos_tenths (pos_d)
	);

	always_ff @(posedge CLK)
	begin
		if (!RST_N)
		begin
			en_q  <= 1'b0;
			bw_q  <= NSRCFG_BW_22;
			tok_q <= 1'b0;
			pos_q <= 10'h000;
		end
		else
		begin
			en_q <= ctrl_q[`NSRCFG_CTRL_EN_BIT];
			// Codes other than 001 keep the 22% mode
			if (mode_field == `NSRCFG_MODE_33)
				bw_q <= NSRCFG_BW_33;
			else
				bw_q <= NSRCFG_BW_22;
			tok_q <= tok_d;
			pos_q <= pos_d;
		end
	end

	assign RDATA          = rdata_q;
	assign RVALID         = rvalid_q;
	assign RQ_ENABLE     = en_q;
	assign RQ_BW_MODE    = bw_q;
	assign RQ_TUNE       = tune_q[5:0];
	assign RQ_TUNE_VALID = tok_q;
	assign RQ_BAND_POS   = pos_q;
endmodule
`default_nettype wire

// *** common/nsrcfg_map.svh ***
// Register offsets, field positions, reset values and limits of the requantizer configuration registers
`ifndef NSRCFG_MAP_SVH
`define NSRCFG_MAP_SVH

// ----------------------------------------
// Offsets
// ----------------------------------------
`define NSRCFG_CTRL_ADDR      8'h3C
`define NSRCFG_TUNE_ADDR      8'h3E

// ----------------------------------------
// Fields and resets
// ----------------------------------------
`define NSRCFG_CTRL_EN_BIT    0
`define NSRCFG_CTRL_MODE_LSB  1
`define NSRCFG_CTRL_MODE_MSB  3
`define NSRCFG_CTRL_MASK      8'h0F
`define NSRCFG_TUNE_MASK      8'h3F
`define NSRCFG_CTRL_RESET     8'h00
`define NSRCFG_TUNE_RESET     8'h1C
`define NSRCFG_MODE_22        3'h0
`define NSRCFG_MODE_33        3'h1

// ----------------------------------------
// Tuning code counts per mode, and step (step in tenths of a percent of the sample rate)
// ----------------------------------------
`define NSRCFG_TUNE_COUNT_22  6'h39
`define NSRCFG_TUNE_COUNT_33  6'h22
`define NSRCFG_STEP_TENTHS    4'h5

`endif

// *** common/nsrcfg_pkg.sv ***
// Types of the requantizer configuration registers
package nsrcfg_pkg;
	typedef logic [7:0] nsrcfg_byte_t;
	typedef logic [5:0] nsrcfg_tune_t;
	typedef enum logic [1:0]
	{
		NSRCFG_BW_22 = 2'b01,
		NSRCFG_BW_33 = 2'b10
	} nsrcfg_bw_t;
endpackage

// *** logic/nsrcfg_tune_limit.sv ***
// Tuning word range check and band position for the selected bandwidth mode
`timescale 1ns/1ps
`default_nettype none
`include "nsrcfg_map.svh"
module nsrcfg_tune_limit
	import nsrcfg_pkg::*;
(
	// Configuration
	input  wire logic             bw_33,
	input  wire nsrcfg_pkg::nsrcfg_tune_t tune,
	// Result
	output logic                  tune_ok,
	output logic [9:0]            band_pos_tenths
);
	always_comb
	begin
		if (bw_33)
			tune_ok = (tune < `NSRCFG_TUNE_COUNT_33);
		else
			tune_ok = (tune < `NSRCFG_TUNE_COUNT_22);
		band_pos_tenths = 10'(tune) * 10'(`NSRCFG_STEP_TENTHS);
	end
endmodule
`default_nettype wire

// *** test/nsrcfg_host.sv ***
// Serial port host model issuing register strobes
`timescale 1ns/1ps
`default_nettype none
module nsrcfg_host
	import nsrcfg_pkg::*;
(
	// Register port
	input	wire logic			CLK,
	output	logic				WR_EN,
	output	logic				RD_EN,
	output	nsrcfg_pkg::nsrcfg_byte_t	ADDR,
	output	nsrcfg_pkg::nsrcfg_byte_t	WDATA,
	input	wire nsrcfg_pkg::nsrcfg_byte_t	RDATA
);
	initial
		{WR_EN, RD_EN, ADDR, WDATA} = '0;
	task automatic xfer(input logic w, input nsrcfg_byte_t a, d, output nsrcfg_byte_t q);
		@(posedge CLK);
		{WR_EN, RD_EN, ADDR, WDATA} <= {w, !w, a, d};
		@(posedge CLK);
		// Released lines show the inverse, strobes drop to idle
		{WR_EN, RD_EN, ADDR, WDATA} <= {2'b00, ~a, ~d};
		#1 q = RDATA;
	endtask
endmodule
`default_nettype wire

// *** test/nsrcfg_regs_chk.sv ***
// Assertions on the requantizer register ports
`timescale 1ns/1ps
`default_nettype none
module nsrcfg_regs_chk
	import nsrcfg_pkg::*;
(
	// Ports watched
	input	wire logic			CLK,
	input	wire logic			RST_N,
	input	wire logic			WR_EN,
	input	wire logic			RD_EN,
	input	wire nsrcfg_pkg::nsrcfg_byte_t	ADDR,
	input	wire nsrcfg_pkg::nsrcfg_byte_t	WDATA,
	input	wire nsrcfg_pkg::nsrcfg_byte_t	RDATA,
	input	wire logic			RVALID,
	input	wire logic			RQ_ENABLE,
	input	wire nsrcfg_pkg::nsrcfg_bw_t	RQ_BW_MODE,
	input	wire nsrcfg_pkg::nsrcfg_tune_t	RQ_TUNE,
	input	wire logic			RQ_TUNE_VALID,
	input	wire logic [9:0]		RQ_BAND_POS
);
	logic [1:0] up_q;
	always_ff @(posedge CLK)
		up_q <= {up_q[0], RST_N};
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N || !up_q[1]);
	sequence s_ctl; WR_EN && ADDR == 8'h3C; endsequence
	sequence s_tun; WR_EN && ADDR == 8'h3E; endsequence
	sequence s_hold; $stable(RQ_TUNE) && $stable(RQ_BW_MODE); endsequence
	chk_ctrl_resv: assert property (RD_EN && ADDR == 8'h3C |=> RVALID && RDATA[7:4] == 4'h0)
		else $error("ctrl read bad");
	chk_tune_resv: assert property (RD_EN && ADDR == 8'h3E |=> RVALID && RDATA[7:6] == 2'h0)
		else $error("tune read bad");
	chk_enable_bit: assert property (s_ctl |=> ##1 RQ_ENABLE == $past(WDATA[0], 2))
		else $error("enable bad");
	chk_mode_22: assert property (s_ctl ##0 WDATA[3:1] == 3'h0 |=> ##1 RQ_BW_MODE == NSRCFG_BW_22)
		else $error("mode 22 bad");
	chk_mode_33: assert property (s_ctl ##0 WDATA[3:1] == 3'h1 |=> ##1 RQ_BW_MODE == NSRCFG_BW_33)
		else $error("mode 33 bad");
	chk_tune_field: assert property (s_tun |=> RQ_TUNE == $past(WDATA[5:0]))
		else $error("tune bad");
	chk_band_step: assert property (RQ_BAND_POS == 10'($past(RQ_TUNE)) * 10'd5)
		else $error("band bad");
	chk_range_22: assert property (s_hold ##0 RQ_BW_MODE == NSRCFG_BW_22 |-> RQ_TUNE_VALID == (RQ_TUNE < 6'd57))
		else $error("range 22 bad");
	chk_range_33: assert property (s_hold ##0 RQ_BW_MODE == NSRCFG_BW_33 |-> RQ_TUNE_VALID == (RQ_TUNE < 6'd34))
		else $error("range 33 bad");
endmodule
bind nsrcfg_regs nsrcfg_regs_chk u_nsrcfg_regs_chk (.*);
`default_nettype wire

// *** test/tb_top.sv ***
// Bench for the requantizer configuration registers
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import nsrcfg_pkg::*;
	logic CLK, RST_N, WR_EN, RD_EN, RVALID, RQ_ENABLE, RQ_TUNE_VALID;
	nsrcfg_byte_t ADDR, WDATA, RDATA, q;
	nsrcfg_bw_t RQ_BW_MODE;
	nsrcfg_tune_t RQ_TUNE;
	logic [9:0] RQ_BAND_POS;
	int err_total, checked;
	// Address, write data, read back, expected tuning valid
	logic [31:0] rows [9] = '{32'h3CF00001, 32'h3E383801, 32'h3E393900, 32'h3C030300,
		32'h3E212101, 32'h3EE22200, 32'h3DFF0000, 32'h3C010101, 32'h3C050501};
	nsrcfg_regs u_nsrcfg_regs (.*);
	nsrcfg_host u_nsrcfg_host (.*);
	task cmp(input nsrcfg_byte_t s, e);
		checked++;
		if (s !== e)
		begin
			err_total++;
			$display("[FAIL] %0t seen %h exp %h", $time, s, e);
		end
	endtask
	task wrap_up;
		$display("checks %0d errors %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial
	begin
		CLK = 0;
		forever #5 CLK = ~CLK;
	end
	initial
	begin
		#20000 err_total++;
		wrap_up;
	end
	initial
	begin
		RST_N = 0;
		repeat (12) @(posedge CLK);
		RST_N <= 1;
		foreach (rows[i])
		begin
			u_nsrcfg_host.xfer(1, rows[i][31:24], rows[i][23:16], q);
			u_nsrcfg_host.xfer(0, rows[i][31:24], 8'h00, q);
			cmp(q, rows[i][15:8]);
			cmp(RVALID, 8'h01);
			repeat (2) @(posedge CLK);
			#1 cmp(RQ_TUNE_VALID, rows[i][7:0]);
		end
		@(posedge CLK) RST_N <= 0;
		repeat (2) @(posedge CLK);
		RST_N <= 1;
		u_nsrcfg_host.xfer(0, 8'h3C, 8'h00, q);
		cmp(q, 8'h00);
		u_nsrcfg_host.xfer(0, 8'h3E, 8'h00, q);
		cmp(q, 8'h1C);
		cmp(RQ_ENABLE, 8'h00);
		cmp(RQ_BW_MODE, 8'h01);
		cmp(RQ_TUNE, 8'h1C);
		cmp(RQ_BAND_POS[7:0], 8'h8C);
		cmp({6'h00, RQ_BAND_POS[9:8]}, 8'h00);
		wrap_up;
	end
endmodule
`default_nettype wire
